// ---- design/sdpb_top.sv ----
// burst terminate, write masking, precharge and auto precharge control
`timescale 1ns/10ps
`default_nettype none
`include "sdpb_map.svh"

module sdpb_top #(
  parameter int RL = `SDPB_RL_DEF,
  parameter int WL = `SDPB_WL_DEF,
  parameter int BL = `SDPB_BL_DEF,
  parameter int DW = 16,
  parameter int NB = DW / 8
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       cs_n,
  input  wire logic [`SDPB_CA_W-1:0]      ca_rise,
  input  wire logic [`SDPB_CA_W-1:0]      ca_fall,
  input  wire logic [DW-1:0]              dq_rise,
  input  wire logic [DW-1:0]              dq_fall,
  input  wire logic [NB-1:0]              write_byte_mask_rise,
  input  wire logic [NB-1:0]              write_byte_mask_fall,
  output logic [`SDPB_NUM_BANKS-1:0]      bank_open,
  output logic [`SDPB_NUM_BANKS-1:0]      precharge_start,
  output logic                            rd_data_en,
  output logic                            wr_data_en,
  output logic [4:0]                      eff_burst_len,
  output logic                            arr_we,
  output logic [2:0]                      arr_bank,
  output logic [4*DW-1:0]                 arr_data,
  output logic [4*NB-1:0]                 arr_byte_en
);

  localparam int HALF      = BL / 2;
  localparam int RTP       = `SDPB_RTP_CYC;
  localparam int RD_AP_D   = (HALF > HALF - 2 + RTP) ? HALF : HALF - 2 + RTP;
  localparam int WR_AP_D   = WL + HALF + `SDPB_WR_AP_GAP;
  localparam int RD_AP_CHK = RD_AP_D + 1;
  localparam int WR_AP_CHK = WR_AP_D + 1;
  localparam int RL_D      = RL;
  localparam int WL_D      = WL;
  localparam int RL_M1     = RL - 1;
  localparam int WL_M1     = WL - 1;
  localparam int NBK       = `SDPB_NUM_BANKS;
  localparam int CW        = `SDPB_CNT_W;

  generate
    if (RL < 1 || WL < 1 || RL > 8 || WL > 8) begin : g_bad_lat
      $error("latencies must lie in 1..8");
    end
    if (BL != 4 && BL != 8 && BL != 16) begin : g_bad_bl
      $error("burst length must be 4, 8 or 16");
    end
    if (RD_AP_D >= (1 << CW) || WR_AP_D >= (1 << CW)) begin : g_bad_cnt
      $error("auto precharge delay exceeds counter");
    end
    if (NB * 8 != DW) begin : g_bad_lanes
      $error("one mask lane per data byte");
    end
  endgenerate

  sdpb_pkg::sdpb_cmd_t cmd;
  logic [2:0]          bank_sel;
  logic                all_banks_flag;
  logic                auto_precharge_flag;

  sdpb_cmd_decode u_decode (
    .cs_n                (cs_n),
    .ca_rise             (ca_rise),
    .ca_fall             (ca_fall),
    .cmd                 (cmd),
    .bank_sel            (bank_sel),
    .all_banks_flag      (all_banks_flag),
    .auto_precharge_flag (auto_precharge_flag)
  );

  // read and write share the burst and auto precharge paths
  function automatic logic is_rw(input sdpb_pkg::sdpb_cmd_t c);
    return (c == sdpb_pkg::cmd_rd) || (c == sdpb_pkg::cmd_wr);
  endfunction

  // burst tracking: one burst in flight, the most recent read or write
  sdpb_pkg::sdpb_burst_t kind_ff, nxt_kind;
  logic [3:0]  age_ff, nxt_age;
  logic [3:0]  half_ff, nxt_half;
  logic        ap_burst_ff, nxt_ap_burst;
  logic        bst_done_ff, nxt_bst_done;
  logic [2:0]  wbank_ff, nxt_wbank;
  logic [4:0]  eff_ff, nxt_eff;
  logic [RL-1:0] rd_pipe_ff, nxt_rd_pipe;
  logic [WL-1:0] wr_pipe_ff, nxt_wr_pipe;
  logic        beat_rd, beat_wr, bst_ok, in_burst;

  always_comb begin
    nxt_kind     = kind_ff;
    nxt_age      = (age_ff == 4'hF) ? age_ff : age_ff + 4'h1;
    nxt_half     = half_ff;
    nxt_ap_burst = ap_burst_ff;
    nxt_bst_done = bst_done_ff;
    nxt_wbank    = wbank_ff;
    nxt_eff      = eff_ff;
    in_burst     = (kind_ff != sdpb_pkg::burst_idle) && ({1'b0, age_ff} + 5'h01 < {1'b0, half_ff});
    // a terminate outside a live burst, or after one already took effect, is ignored
    bst_ok       = (cmd == sdpb_pkg::cmd_bst) && in_burst && !bst_done_ff && !ap_burst_ff;
    beat_rd      = (kind_ff == sdpb_pkg::burst_read) && in_burst && !bst_ok;
    beat_wr      = (kind_ff == sdpb_pkg::burst_write) && in_burst && !bst_ok;
    if (bst_ok) begin
      nxt_bst_done = 1'b1;
      nxt_eff      = {age_ff + 4'h1, 1'b0};
      nxt_half     = age_ff + 4'h1;
    end
    if (is_rw(cmd)) begin
      nxt_kind     = (cmd == sdpb_pkg::cmd_rd) ? sdpb_pkg::burst_read : sdpb_pkg::burst_write;
      nxt_age      = 4'h0;
      nxt_half     = 4'(HALF);
      nxt_ap_burst = auto_precharge_flag;
      nxt_bst_done = 1'b0;
      nxt_wbank    = bank_sel;
      nxt_eff      = 5'(BL);
      beat_rd      = (cmd == sdpb_pkg::cmd_rd);
      beat_wr      = (cmd == sdpb_pkg::cmd_wr);
    end
    // oldest stage falls off the top of each latency pipe
    nxt_rd_pipe = RL'({rd_pipe_ff, beat_rd});
    nxt_wr_pipe = WL'({wr_pipe_ff, beat_wr});
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kind_ff     <= sdpb_pkg::burst_idle;
      age_ff      <= 4'h0;
      half_ff     <= 4'h0;
      ap_burst_ff <= 1'b0;
      bst_done_ff <= 1'b0;
      wbank_ff    <= 3'h0;
      eff_ff      <= 5'h00;
      rd_pipe_ff  <= '0;
      wr_pipe_ff  <= '0;
    end else begin
      kind_ff     <= nxt_kind;
      age_ff      <= nxt_age;
      half_ff     <= nxt_half;
      ap_burst_ff <= nxt_ap_burst;
      bst_done_ff <= nxt_bst_done;
      wbank_ff    <= nxt_wbank;
      eff_ff      <= nxt_eff;
      rd_pipe_ff  <= nxt_rd_pipe;
      wr_pipe_ff  <= nxt_wr_pipe;
    end
  end

  // bank state and precharge, one auto precharge counter per bank
  logic [NBK-1:0]  open_ff, nxt_open;
  logic [NBK-1:0]  pre_ff, nxt_pre;
  logic [CW-1:0]   ap_cnt_ff [NBK];
  logic [CW-1:0]   nxt_ap_cnt [NBK];
  logic            ap_any;

  always_comb begin
    nxt_open = open_ff;
    nxt_pre  = '0;
    ap_any   = 1'b0;
    for (int b = 0; b < NBK; b++) begin
      nxt_ap_cnt[b] = ap_cnt_ff[b];
      if (ap_cnt_ff[b] != '0) begin
        ap_any        = 1'b1;
        nxt_ap_cnt[b] = ap_cnt_ff[b] - 1'b1;
        if (ap_cnt_ff[b] == CW'(1)) begin
          nxt_pre[b] = 1'b1;
        end
      end
    end
    if (cmd == sdpb_pkg::cmd_pre) begin
      if (all_banks_flag) begin
        nxt_pre = '1;
      end else begin
        nxt_pre[bank_sel] = 1'b1;
      end
    end
    // auto precharge low leaves the bank open after the burst
    if (is_rw(cmd) && auto_precharge_flag) begin
      nxt_ap_cnt[bank_sel] = (cmd == sdpb_pkg::cmd_rd) ? CW'(RD_AP_D) : CW'(WR_AP_D);
    end
    nxt_open = nxt_open & ~nxt_pre;
    // activate sets the bank last so a same-cycle closing pulse cannot hide it
    if (cmd == sdpb_pkg::cmd_act) begin
      nxt_open[bank_sel] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      open_ff <= '0;
      pre_ff  <= '0;
      for (int b = 0; b < NBK; b++) begin
        ap_cnt_ff[b] <= '0;
      end
    end else begin
      open_ff <= nxt_open;
      pre_ff  <= nxt_pre;
      for (int b = 0; b < NBK; b++) begin
        ap_cnt_ff[b] <= nxt_ap_cnt[b];
      end
    end
  end

  sdpb_write_merge #(
    .DW (DW),
    .NB (NB)
  ) u_merge (
    .clk                  (clk),
    .reset_n              (reset_n),
    .beat_valid           (wr_pipe_ff[WL-1]),
    .bank_in              (wbank_ff),
    .dq_rise              (dq_rise),
    .dq_fall              (dq_fall),
    .write_byte_mask_rise (write_byte_mask_rise),
    .write_byte_mask_fall (write_byte_mask_fall),
    .arr_we               (arr_we),
    .arr_bank             (arr_bank),
    .arr_data             (arr_data),
    .arr_byte_en          (arr_byte_en)
  );

  assign bank_open       = open_ff;
  assign precharge_start = pre_ff;
  assign rd_data_en      = rd_pipe_ff[RL-1];
  assign wr_data_en      = wr_pipe_ff[WL-1];
  assign eff_burst_len   = eff_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_rd_bst_stop: assert property (bst_ok && kind_ff == sdpb_pkg::burst_read |-> ##RL_D !rd_data_en)
    else $error("read data did not stop after terminate");
  a_wr_bst_stop: assert property (bst_ok && kind_ff == sdpb_pkg::burst_write |-> ##WL_D !wr_data_en)
    else $error("write window did not stop after terminate");
  a_pre_single: assert property (!cs_n && ca_rise[3:0] == 4'hB && !ca_rise[4]
      |=> precharge_start[$past(bank_sel)] && !bank_open[$past(bank_sel)])
    else $error("single bank precharge not taken");
  a_pre_all_banks: assert property (cmd == sdpb_pkg::cmd_pre && all_banks_flag |=> precharge_start == '1)
    else $error("all bank precharge did not close every bank");
  a_bst_eff_len: assert property (!cs_n && ca_rise[3:0] == 4'h3 && bst_ok
      |=> eff_burst_len == {$past(age_ff) + 4'h1, 1'b0})
    else $error("effective burst length wrong after terminate");
  a_rd_ap_time: assert property (cmd == sdpb_pkg::cmd_rd && auto_precharge_flag
      |-> ##RD_AP_CHK precharge_start != '0)
    else $error("read auto precharge at wrong edge");
  a_wr_ap_time: assert property (cmd == sdpb_pkg::cmd_wr && auto_precharge_flag
      |-> ##WR_AP_CHK precharge_start != '0)
    else $error("write auto precharge at wrong edge");
  a_no_ap_open: assert property (is_rw(cmd) && !auto_precharge_flag && !ap_any
      |=> !ap_any && precharge_start == '0)
    else $error("bank closed without auto precharge");
  a_ap_armed: assert property (is_rw(cmd) && auto_precharge_flag |=> ap_any)
    else $error("auto precharge counter not started");
  a_bst_ignored: assert property (cmd == sdpb_pkg::cmd_bst && !bst_ok
      |=> eff_burst_len == $past(eff_burst_len))
    else $error("refused terminate changed the burst length");
  a_rw_full_len: assert property (is_rw(cmd) |=> eff_burst_len == 5'(BL))
    else $error("new burst did not restore full length");
  a_rd_runs_to_bst: assert property (bst_ok && kind_ff == sdpb_pkg::burst_read
      |-> ##RL_M1 rd_data_en)
    else $error("read data stopped before the terminate");
  a_wr_runs_to_bst: assert property (bst_ok && kind_ff == sdpb_pkg::burst_write
      |-> ##WL_M1 wr_data_en)
    else $error("write window stopped before the terminate");
  // only an activate in the same cycle may leave a pulsed bank open
  a_pre_closes: assert property (cmd != sdpb_pkg::cmd_act |=> (bank_open & precharge_start) == '0)
    else $error("precharged bank still open");
  c_rd_bst: cover property (bst_ok && kind_ff == sdpb_pkg::burst_read);
  c_wr_bst: cover property (bst_ok && kind_ff == sdpb_pkg::burst_write);
  c_wr_ap: cover property (cmd == sdpb_pkg::cmd_wr && auto_precharge_flag);
  c_pre_all: cover property (cmd == sdpb_pkg::cmd_pre && all_banks_flag);

endmodule
`default_nettype wire

// ---- design/sdpb_map.svh ----
// constants for the precharge and burst-terminate block
// Functional notes
// - write burst stops WL after terminate
// - read output stops RL after terminate
// - one mask per byte lane, masks beat
// - mask sampled exactly like write data
// - precharge decodes as CA 1,1,0,1
// - all-banks flag closes all, else bank bits
// - array write only after full 4-beat group
// - auto precharge low keeps bank open
// - auto precharge high closes bank itself
// - read auto precharge at later of two points
// - write auto precharge two cycles after burst
// - terminate decodes as CA 1,1,0,0
// - effective length is twice cycles to terminate
`ifndef SDPB_MAP_SVH
`define SDPB_MAP_SVH

`define SDPB_CA_W          10
`define SDPB_CA_ALL_BANKS  4
`define SDPB_CA_BANK_LO    7
`define SDPB_CA_BANK_HI    9
`define SDPB_CA_AUTO_PRE   0
`define SDPB_NUM_BANKS     8

`define SDPB_RL_DEF        3
`define SDPB_WL_DEF        1
`define SDPB_BL_DEF        8
`define SDPB_PREFETCH      4

`define SDPB_T_CK_NS       40
`define SDPB_T_RTP_NS      8
`define SDPB_RTP_CYC       (((`SDPB_T_RTP_NS + `SDPB_T_CK_NS - 1) / `SDPB_T_CK_NS) < 1 ? 1 : \
                            ((`SDPB_T_RTP_NS + `SDPB_T_CK_NS - 1) / `SDPB_T_CK_NS))
`define SDPB_WR_AP_GAP     2
`define SDPB_CNT_W         6

`endif

// ---- design/sdpb_pkg.sv ----
// types shared by the precharge and burst-terminate block
package sdpb_pkg;

  typedef enum logic [2:0] {
    cmd_nop,
    cmd_act,
    cmd_rd,
    cmd_wr,
    cmd_bst,
    cmd_pre,
    cmd_other
  } sdpb_cmd_t;

  typedef enum logic [1:0] {
    burst_idle,
    burst_read,
    burst_write
  } sdpb_burst_t;

endpackage

// ---- design/sdpb_cmd_decode.sv ----
// command decoder for chip select and the command/address bus
`timescale 1ns/10ps
`default_nettype none
`include "sdpb_map.svh"

module sdpb_cmd_decode (
  input  wire logic                     cs_n,
  input  wire logic [`SDPB_CA_W-1:0]    ca_rise,
  input  wire logic [`SDPB_CA_W-1:0]    ca_fall,
  output sdpb_pkg::sdpb_cmd_t           cmd,
  output logic [2:0]                    bank_sel,
  output logic                          all_banks_flag,
  output logic                          auto_precharge_flag
);

  function automatic sdpb_pkg::sdpb_cmd_t decode_cmd(input logic csn, input logic [3:0] c);
    sdpb_pkg::sdpb_cmd_t r;
    r = sdpb_pkg::cmd_other;
    if (csn) begin
      r = sdpb_pkg::cmd_nop;
    end else if (c[0] && c[1] && !c[2]) begin
      r = c[3] ? sdpb_pkg::cmd_pre : sdpb_pkg::cmd_bst;
    end else if (c[0] && !c[1]) begin
      r = c[2] ? sdpb_pkg::cmd_rd : sdpb_pkg::cmd_wr;
    end else if (!c[0] && c[1]) begin
      r = sdpb_pkg::cmd_act;
    end
    return r;
  endfunction

  always_comb begin
    cmd                 = decode_cmd(cs_n, ca_rise[3:0]);
    bank_sel            = ca_rise[`SDPB_CA_BANK_HI:`SDPB_CA_BANK_LO];
    all_banks_flag      = ca_rise[`SDPB_CA_ALL_BANKS];
    auto_precharge_flag = ca_fall[`SDPB_CA_AUTO_PRE];
  end

endmodule
`default_nettype wire

// ---- design/sdpb_write_merge.sv ----
// gathers write beats into 4-beat prefetch groups for the array
`timescale 1ns/10ps
`default_nettype none
`include "sdpb_map.svh"

module sdpb_write_merge #(
  parameter int DW = 16,
  parameter int NB = DW / 8
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 beat_valid,
  input  wire logic [2:0]           bank_in,
  input  wire logic [DW-1:0]        dq_rise,
  input  wire logic [DW-1:0]        dq_fall,
  input  wire logic [NB-1:0]        write_byte_mask_rise,
  input  wire logic [NB-1:0]        write_byte_mask_fall,
  output logic                      arr_we,
  output logic [2:0]                arr_bank,
  output logic [4*DW-1:0]           arr_data,
  output logic [4*NB-1:0]           arr_byte_en
);

  generate
    if (DW % 8 != 0 || NB * 8 != DW) begin : g_bad_width
      $error("data width must be whole bytes");
    end
  endgenerate

  logic              second_ff, nxt_second;
  logic [2*DW-1:0]   first_data_ff, nxt_first_data;
  logic [2*NB-1:0]   first_mask_ff, nxt_first_mask;
  logic              we_ff, nxt_we;
  logic [2:0]        bank_ff, nxt_bank;
  logic [4*DW-1:0]   data_ff, nxt_data;
  logic [4*NB-1:0]   be_ff, nxt_be;

  // mask travels beside its beat through the same flops as the data
  always_comb begin
    nxt_second     = 1'b0;
    nxt_first_data = first_data_ff;
    nxt_first_mask = first_mask_ff;
    nxt_we         = 1'b0;
    nxt_bank       = bank_ff;
    nxt_data       = data_ff;
    nxt_be         = be_ff;
    if (beat_valid) begin
      if (!second_ff) begin
        nxt_second     = 1'b1;
        nxt_first_data = {dq_fall, dq_rise};
        nxt_first_mask = {write_byte_mask_fall, write_byte_mask_rise};
      end else begin
        nxt_we   = 1'b1;
        nxt_bank = bank_in;
        nxt_data = {dq_fall, dq_rise, first_data_ff};
        nxt_be   = ~{write_byte_mask_fall, write_byte_mask_rise, first_mask_ff};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      second_ff     <= 1'b0;
      first_data_ff <= '0;
      first_mask_ff <= '0;
      we_ff         <= 1'b0;
      bank_ff       <= 3'h0;
      data_ff       <= '0;
      be_ff         <= '0;
    end else begin
      second_ff     <= nxt_second;
      first_data_ff <= nxt_first_data;
      first_mask_ff <= nxt_first_mask;
      we_ff         <= nxt_we;
      bank_ff       <= nxt_bank;
      data_ff       <= nxt_data;
      be_ff         <= nxt_be;
    end
  end

  assign arr_we      = we_ff;
  assign arr_bank    = bank_ff;
  assign arr_data    = data_ff;
  assign arr_byte_en = be_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_group_complete: assert property (arr_we |-> $past(beat_valid, 1) && $past(beat_valid, 2))
    else $error("array write without a full prefetch group");
  a_mask_lanes: assert property (arr_we |-> arr_byte_en == ~{$past(write_byte_mask_fall),
      $past(write_byte_mask_rise), $past(write_byte_mask_fall, 2), $past(write_byte_mask_rise, 2)})
    else $error("byte enables do not follow the write mask");
  c_array_write: cover property (arr_we && arr_byte_en != '1);

endmodule
`default_nettype wire

// ---- test/sdpb_ctrl_model.sv ----
// controller stand-in: commands, idle gaps and free-running write data
`timescale 1ns/10ps
`default_nettype none
`include "sdpb_map.svh"
module sdpb_ctrl_model #(
  parameter int BL     = 8,
  parameter int WL     = 1,
  parameter int T_RAS  = 3,
  parameter int T_RP   = 2,
  parameter int T_RPAB = 3,
  parameter int T_WR   = 2,
  parameter int DW     = 16,
  parameter int NB     = DW / 8
) (
  input  wire logic                  clk,
  output logic                       cs_n,
  output logic [`SDPB_CA_W-1:0]      ca_rise,
  output logic [`SDPB_CA_W-1:0]      ca_fall,
  output logic [DW-1:0]              dq_rise,
  output logic [DW-1:0]              dq_fall,
  output logic [NB-1:0]              write_byte_mask_rise,
  output logic [NB-1:0]              write_byte_mask_fall
);
  localparam int RTP    = `SDPB_RTP_CYC;
  localparam int RD_PRE = BL / 2 + ((RTP > 2) ? RTP : 2) - 2;
  localparam int WR_PRE = WL + BL / 2 + 1 + T_WR;
  // full burst spacing even when truncated: safe, only slower
  localparam int SETTLE = ((WR_PRE > RD_PRE) ? WR_PRE : RD_PRE) + T_RPAB + 4;

  initial begin
    cs_n = 1'b1;
    {ca_rise, ca_fall} = '0;
    {dq_rise, dq_fall, write_byte_mask_rise, write_byte_mask_fall} = '0;
  end

  // data pins change every cycle so a stale beat never looks valid
  always @(posedge clk) begin
    #2;
    {dq_rise, dq_fall, write_byte_mask_rise, write_byte_mask_fall} = 36'({$urandom, $urandom});
  end

  // caller sits 2 ns after an edge; command is taken at the next edge
  task automatic issue(input logic [3:0] code, input logic [2:0] bk, input logic ab, input logic ap);
    cs_n = 1'b0;
    ca_rise = {bk, 2'($urandom), ab, code};
    ca_fall = {9'($urandom), ap};
    @(posedge clk);
    #2;
  endtask

  // deselected cycles carry random codes that must be ignored
  task automatic idle(input int n);
    repeat (n) begin
      cs_n = 1'b1;
      {ca_rise, ca_fall} = 20'($urandom);
      @(posedge clk);
      #2;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/sdpb_precharge_burst_term_bench.sv ----
// self-checking bench with a cycle model of the precharge and terminate block
`timescale 1ns/10ps
`default_nettype none
`include "sdpb_map.svh"
module sdram_precharge_burst_term_bench;
  localparam int RL = 3;
  localparam int WL = 1;
  localparam int BL = 8;
  localparam int RTP = `SDPB_RTP_CYC;
  localparam int RD_AP = (BL / 2 > BL / 2 - 2 + RTP) ? BL / 2 : BL / 2 - 2 + RTP;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cs_n;
  logic [9:0]  ca_rise;
  logic [9:0]  ca_fall;
  logic [15:0] dq_rise;
  logic [15:0] dq_fall;
  logic [1:0]  write_byte_mask_rise;
  logic [1:0]  write_byte_mask_fall;
  logic [7:0]  bank_open;
  logic [7:0]  precharge_start;
  logic        rd_data_en;
  logic        wr_data_en;
  logic [4:0]  eff_burst_len;
  logic        arr_we;
  logic [2:0]  arr_bank;
  logic [63:0] arr_data;
  logic [7:0]  arr_byte_en;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [7:0]  e_pre [int];
  logic        e_rd [int];
  logic        e_wr [int];
  logic [2:0]  e_wbk [int];
  logic [74:0] e_arr [int];
  logic [7:0]  m_open;
  logic [7:0]  pm;
  logic [7:0]  am;
  logic [4:0]  m_eff;
  logic [31:0] h_dat;
  logic [3:0]  h_msk;
  logic        kap;
  logic        kbst;
  logic [2:0]  b;
  int          ec;
  int          kb;
  int          kind;
  int          half;
  int          j;

  sdpb_top #(.RL(RL), .WL(WL), .BL(BL)) DUT (
    .clk, .reset_n, .cs_n, .ca_rise, .ca_fall, .dq_rise, .dq_fall,
    .write_byte_mask_rise, .write_byte_mask_fall, .bank_open, .precharge_start,
    .rd_data_en, .wr_data_en, .eff_burst_len, .arr_we, .arr_bank, .arr_data, .arr_byte_en
  );
  sdpb_ctrl_model #(.BL(BL), .WL(WL)) ctrl (
    .clk, .cs_n, .ca_rise, .ca_fall, .dq_rise, .dq_fall,
    .write_byte_mask_rise, .write_byte_mask_fall
  );

  always #20 clk = ~clk;

  function automatic void add_pre(int idx, logic [2:0] bk);
    e_pre[idx] = (e_pre.exists(idx) ? e_pre[idx] : 8'h00) | (8'h01 << bk);
  endfunction

  // reference model: expectations are keyed by the edge after which they show
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ec = 0;
      kind = 0;
      half = 0;
      m_open = 8'h00;
      m_eff = 5'h00;
      e_pre.delete();
      e_rd.delete();
      e_wr.delete();
      e_arr.delete();
    end else begin
      ec++;
      if (e_wr.exists(ec - 1) && e_wr[ec - 1]) begin
        if (half == 0) begin
          h_dat = {dq_fall, dq_rise};
          h_msk = {write_byte_mask_fall, write_byte_mask_rise};
        end else begin
          e_arr[ec] = {e_wbk[ec - 1], ~{write_byte_mask_fall, write_byte_mask_rise, h_msk},
                       dq_fall, dq_rise, h_dat};
        end
        half = 1 - half;
      end
      pm = e_pre.exists(ec) ? e_pre[ec] : 8'h00;
      am = 8'h00;
      b = ca_rise[9:7];
      j = ec - kb;
      if (!cs_n) begin
        case (ca_rise[3:0])
          4'h2: am[b] = 1'b1;
          4'hB: pm = pm | (ca_rise[4] ? 8'hFF : 8'h01 << b);
          4'h1, 4'h5: begin
            kb = ec;
            kap = ca_fall[0];
            kbst = 1'b0;
            m_eff = 5'(BL);
            kind = ca_rise[2] ? 1 : 2;
            half = 0;
            for (int i = 0; i < BL / 2; i++) begin
              if (ca_rise[2]) begin
                e_rd[ec + RL - 1 + i] = 1'b1;
              end else begin
                e_wr[ec + WL - 1 + i] = 1'b1;
                e_wbk[ec + WL - 1 + i] = b;
              end
            end
            if (kap) add_pre(ec + (ca_rise[2] ? RD_AP : WL + BL / 2 + 2), b);
          end
          4'h3: if (kind != 0 && !kap && !kbst && j < BL / 2) begin
            kbst = 1'b1;
            m_eff = 5'(2 * j);
            for (int i = 0; i < BL; i++) begin
              if (kind == 1) e_rd[ec + RL - 1 + i] = 1'b0;
              else e_wr[ec + WL - 1 + i] = 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (pm != 8'h00) e_pre[ec] = pm;
      m_open = (m_open & ~pm) | am;
    end
  end

  task automatic chk_ctl(string nm, logic [7:0] ex, logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  task automatic chk_arr(string nm, logic [74:0] ex, logic [74:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  // outputs are settled half a cycle after the edge
  always @(negedge clk) begin
    if (reset_n) begin
      chk_ctl("bank_open", m_open, bank_open);
      chk_ctl("precharge_start", e_pre.exists(ec) ? e_pre[ec] : 8'h00, precharge_start);
      chk_ctl("rd_data_en", 8'(e_rd.exists(ec) && e_rd[ec]), 8'(rd_data_en));
      chk_ctl("wr_data_en", 8'(e_wr.exists(ec) && e_wr[ec]), 8'(wr_data_en));
      chk_ctl("eff_burst_len", 8'(m_eff), 8'(eff_burst_len));
      chk_ctl("arr_we", 8'(e_arr.exists(ec)), 8'(arr_we));
      if (e_arr.exists(ec)) chk_arr("arr_write", e_arr[ec], {arr_bank, arr_byte_en, arr_data});
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #80000;
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [2:0] rb;
    logic       ap;
    void'($urandom(64));
    #62;
    reset_n = 1'b1;
    @(posedge clk);
    #2;
    for (int i = 0; i < 8; i++) ctrl.issue(4'h2, 3'(i), 1'b0, 1'b0);
    ctrl.idle(ctrl.T_RAS);
    for (int i = 7; i >= 0; i--) ctrl.issue(4'hB, 3'(i), 1'b0, 1'b0);
    ctrl.idle(ctrl.T_RP);
    for (int i = 0; i < 8; i++) ctrl.issue(4'h2, 3'(i), 1'b0, 1'b0);
    ctrl.idle(ctrl.T_RAS);
    ctrl.issue(4'hB, 3'($urandom), 1'b1, 1'b0);
    ctrl.idle(ctrl.T_RPAB);
    ctrl.issue(4'h2, 3'd1, 1'b0, 1'b0);
    ctrl.issue(4'h2, 3'd2, 1'b0, 1'b0);
    ctrl.idle(ctrl.T_RAS);
    // seamless writes to two banks, banks stay open
    ctrl.issue(4'h1, 3'd1, 1'b0, 1'b0);
    ctrl.idle(BL / 2 - 1);
    ctrl.issue(4'h1, 3'd2, 1'b0, 1'b0);
    ctrl.idle(ctrl.SETTLE);
    // write cut after two cycles, a second terminate must be ignored
    ctrl.issue(4'h1, 3'd2, 1'b0, 1'b0);
    ctrl.idle(1);
    ctrl.issue(4'h3, 3'd0, 1'b0, 1'b0);
    ctrl.idle(1);
    ctrl.issue(4'h3, 3'd0, 1'b0, 1'b0);
    ctrl.idle(ctrl.SETTLE);
    // read cut after two cycles, then a terminate with no live burst left
    ctrl.issue(4'h5, 3'd1, 1'b0, 1'b0);
    ctrl.idle(1);
    ctrl.issue(4'h3, 3'd0, 1'b0, 1'b0);
    ctrl.idle(ctrl.SETTLE);
    ctrl.issue(4'h5, 3'd2, 1'b0, 1'b0);
    ctrl.idle(3);
    ctrl.issue(4'h3, 3'd0, 1'b0, 1'b0);
    ctrl.idle(ctrl.SETTLE);
    // auto precharge read refuses a terminate, then auto precharge write
    ctrl.issue(4'h5, 3'd1, 1'b0, 1'b1);
    ctrl.idle(1);
    ctrl.issue(4'h3, 3'd0, 1'b0, 1'b0);
    ctrl.idle(ctrl.SETTLE);
    ctrl.issue(4'h1, 3'd2, 1'b0, 1'b1);
    ctrl.idle(ctrl.SETTLE);
    repeat (8) begin
      rb = 3'($urandom);
      ap = 1'($urandom);
      ctrl.issue(4'h2, rb, 1'b0, 1'b0);
      ctrl.idle(ctrl.T_RAS);
      ctrl.issue(1'($urandom) ? 4'h5 : 4'h1, rb, 1'b0, ap);
      ctrl.idle(ctrl.SETTLE);
      if (!ap) ctrl.issue(4'hB, rb, 1'b0, 1'b0);
      ctrl.idle(ctrl.T_RP);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
